// ---- dv/oofd_decoder_asserts.sv ----
// Checker: concurrent properties on the operand decoder ports
module oofd_decoder_asserts (
    input wire logic                pclk,
    input wire logic                presetn,
    input wire logic                psel,
    input wire logic                penable,
    input wire logic                pwrite,
    input wire logic [13:0]         paddr,
    input wire logic [31:0]         pwdata,
    input wire logic [31:0]         prdata,
    input wire logic                pready,
    input wire logic                pslverr,
    input wire logic [15:0]         instr_word,
    input wire logic [15:0]         instr_next,
    input wire logic                instr_valid,
    input wire oofd_pkg::oofd_fmt_t instr_fmt,
    input wire logic [15:0]         mul_product,
    input wire logic                mul_load,
    input wire oofd_pkg::oofd_dec_t dec_out
);
    logic        fetch_ok;
    logic [20:0] rel_exp;
    // --------------------------------
    // Helper terms
    // --------------------------------
    // Fetched word that is not a lone second word
    assign fetch_ok = instr_valid && (instr_word[15:12] != 4'hf);
    // Sign-extended branch offset, long form for opcode d
    assign rel_exp = (instr_word[15:12] == 4'hd) ?
                     {{10{instr_word[10]}}, instr_word[10:0]} :
                     {{13{instr_word[7]}}, instr_word[7:0]};
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // --------------------------------
    // Properties
    // --------------------------------
    chk_access_ram: assert property (
        fetch_ok && instr_fmt == oofd_pkg::OOFD_FMT_BYTE && !instr_word[8]
        |=> dec_out.file_addr == {{4{$past(instr_word[7])}},
                                  $past(instr_word[7:0])})
        else $error("access ram address wrong");
    chk_dest_sel: assert property (
        fetch_ok && instr_fmt == oofd_pkg::OOFD_FMT_BYTE
        |=> dec_out.dest_file == $past(instr_word[9]))
        else $error("destination select wrong");
    chk_bit_pick: assert property (
        fetch_ok && instr_fmt == oofd_pkg::OOFD_FMT_BIT
        |=> dec_out.bit_mask == (8'h01 << $past(instr_word[11:9])))
        else $error("bit mask wrong");
    chk_move_addr: assert property (
        fetch_ok && instr_fmt == oofd_pkg::OOFD_FMT_MOVE
        |=> dec_out.move_src == $past(instr_word[11:0])
            && dec_out.move_dst == $past(instr_next[11:0]))
        else $error("move addresses wrong");
    chk_lit_byte: assert property (
        fetch_ok && instr_fmt == oofd_pkg::OOFD_FMT_LIT8
        |=> dec_out.literal == {12'h000, $past(instr_word[7:0])})
        else $error("byte literal wrong");
    chk_abs_target: assert property (
        fetch_ok && instr_fmt == oofd_pkg::OOFD_FMT_LIT20
        |=> dec_out.branch_abs && dec_out.literal ==
            {$past(instr_next[11:0]), $past(instr_word[7:0])}
            && dec_out.fast_shadow == $past(instr_word[8]))
        else $error("absolute target wrong");
    chk_rel_offset: assert property (
        fetch_ok && instr_fmt == oofd_pkg::OOFD_FMT_REL
        |=> dec_out.branch_offs == $past(rel_exp))
        else $error("relative offset wrong");
    chk_table_mode: assert property (
        fetch_ok && instr_fmt == oofd_pkg::OOFD_FMT_TABLE
        |=> dec_out.tbl_mode == $past(instr_word[1:0]))
        else $error("table mode wrong");
    chk_lone_nop: assert property (
        instr_valid && instr_word[15:12] == 4'hf
        |=> dec_out.is_nop && dec_out.file_addr == 12'h000)
        else $error("lone second word not a no-op");
    // Main scenarios reached
    cover property (fetch_ok && instr_fmt == oofd_pkg::OOFD_FMT_MOVE);
    cover property (fetch_ok && instr_fmt == oofd_pkg::OOFD_FMT_REL);
    cover property (psel && penable && pslverr);
endmodule

bind oofd_decoder oofd_decoder_asserts oofd_decoder_asserts_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .instr_word(instr_word),
    .instr_next(instr_next), .instr_valid(instr_valid),
    .instr_fmt(instr_fmt), .mul_product(mul_product),
    .mul_load(mul_load), .dec_out(dec_out));

// ---- dv/tb_top.sv ----
// Testbench: drives the operand decoder over APB and the fetch port
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic                pclk, presetn, psel, penable, pwrite;
    logic                pready, pslverr, instr_valid, mul_load, err;
    logic [13:0]         paddr;
    logic [31:0]         pwdata, prdata, rd;
    logic [15:0]         instr_word, instr_next, mul_product;
    oofd_pkg::oofd_fmt_t instr_fmt;
    oofd_pkg::oofd_dec_t dec_out;
    int                  n_fail, num_checks;
    logic [11:0] idx [9] = '{12'hfe8, 12'hff3, 12'hff4, 12'hff5, 12'hff6,
                             12'hff9, 12'hffa, 12'hffb, 12'h100};
    logic [31:0] msk [9] = '{32'hff, 32'hff, 32'hff, 32'hff, 32'h1fffff,
                             32'hff, 32'hff, 32'hff, 32'hf};

    oofd_decoder oofd_decoder_i (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .instr_word(instr_word),
        .instr_next(instr_next), .instr_valid(instr_valid),
        .instr_fmt(instr_fmt), .mul_product(mul_product),
        .mul_load(mul_load), .dec_out(dec_out));

    // --------------------------------
    // Shared tasks
    // --------------------------------
    task end_sim;
        if (n_fail == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One APB transfer; holds the request until pready is seen high, failing and ending the run after 20 cycles
    task apb(input logic wr, input logic [11:0] ix, input logic [31:0] wd);
        int n;
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr;
        paddr <= {ix, 2'b00}; pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (n == 20) begin
            n_fail++;
            end_sim;
        end
        rd = prdata; err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    // Present one instruction on the fetch port, look after the decode
    task dec(input logic [15:0] w, nx, input oofd_pkg::oofd_fmt_t f);
        @(posedge pclk);
        instr_word <= w; instr_next <= nx; instr_fmt <= f;
        instr_valid <= 1'b1;
        @(posedge pclk);
        #1;
    endtask

    // --------------------------------
    // Scenarios
    // --------------------------------
    task t_regs;
        for (int i = 0; i < 9; i++) begin
            apb(1'b0, idx[i], 32'h0); chk(rd, 32'h0);
            apb(1'b1, idx[i], 32'hffffffff);
            apb(1'b0, idx[i], 32'h0); chk(rd, msk[i]);
        end
        apb(1'b1, 12'h200, 32'h12345678); chk(err, 1'b1);
        apb(1'b0, 12'h200, 32'h0); chk(rd, 32'h0);
        chk(err, 1'b1);
    endtask
    task t_bank;
        apb(1'b1, 12'h100, 32'h5);
        dec(16'h2534, 16'h0, oofd_pkg::OOFD_FMT_BYTE);
        chk(dec_out.file_addr, 12'h534);
        chk(dec_out.dest_file, 1'b0);
        dec(16'h2634, 16'h0, oofd_pkg::OOFD_FMT_BYTE);
        chk(dec_out.file_addr, 12'h034);
        chk(dec_out.dest_file, 1'b1);
        dec(16'h249a, 16'h0, oofd_pkg::OOFD_FMT_BYTE);
        chk(dec_out.file_addr, 12'hf9a);
        for (int b = 0; b < 8; b++) begin
            dec({4'h9, b[2:0], 9'h1ff}, 16'h0, oofd_pkg::OOFD_FMT_BIT);
            chk(dec_out.bit_mask, 8'h01 << b);
            chk(dec_out.file_addr, 12'h5ff);
        end
    endtask
    task t_fields;
        dec(16'hc123, 16'hfabc, oofd_pkg::OOFD_FMT_MOVE);
        chk(dec_out.move_src, 12'h123);
        chk(dec_out.move_dst, 12'habc);
        dec(16'hfabc, 16'h0, oofd_pkg::OOFD_FMT_MOVE);
        chk(dec_out.is_nop, 1'b1);
        chk(dec_out.move_src, 12'h000);
        dec(16'h0e7f, 16'h0, oofd_pkg::OOFD_FMT_LIT8);
        chk(dec_out.literal, 20'h0007f);
        dec(16'hee1a, 16'hf0bc, oofd_pkg::OOFD_FMT_LIT12);
        chk(dec_out.literal, 20'h00abc);
        dec(16'hed12, 16'hf345, oofd_pkg::OOFD_FMT_LIT20);
        chk(dec_out.literal, 20'h34512);
        chk({dec_out.branch_abs, dec_out.fast_shadow}, 2'b11);
        dec(16'hec12, 16'hf345, oofd_pkg::OOFD_FMT_LIT20);
        chk(dec_out.fast_shadow, 1'b0);
        dec(16'hd7ff, 16'h0, oofd_pkg::OOFD_FMT_REL);
        chk(dec_out.branch_offs, 21'h1fffff);
        dec(16'he280, 16'h0, oofd_pkg::OOFD_FMT_REL);
        chk(dec_out.branch_offs, 21'h1fff80);
        dec(16'he27f, 16'h0, oofd_pkg::OOFD_FMT_REL);
        chk(dec_out.branch_offs, 21'h00007f);
        for (int m = 0; m < 4; m++) begin
            dec({14'h0002, m[1:0]}, 16'h0, oofd_pkg::OOFD_FMT_TABLE);
            chk(dec_out.tbl_mode, m[1:0]);
        end
        dec(16'h0013, 16'h0, oofd_pkg::OOFD_FMT_TABLE);
        chk(dec_out.fast_shadow, 1'b1);
        dec(16'h0012, 16'h0, oofd_pkg::OOFD_FMT_TABLE);
        chk(dec_out.fast_shadow, 1'b0);
    endtask
    task t_soft_mul;
        @(posedge pclk);
        instr_valid <= 1'b0; instr_fmt <= oofd_pkg::OOFD_FMT_MOVE;
        mul_product <= 16'habcd; mul_load <= 1'b1;
        @(posedge pclk);
        mul_load <= 1'b0;
        apb(1'b0, 12'hff3, 32'h0); chk(rd, 32'hcd);
        apb(1'b0, 12'hff4, 32'h0); chk(rd, 32'hab);
        apb(1'b1, 12'h101, 32'hfabcc123);
        apb(1'b0, 12'h104, 32'h0); chk(rd, 32'h00abc123);
    endtask

    // Free-running core clock
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    // Main sequence
    initial begin
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 14'h0000; pwdata = 32'h0; instr_word = 16'h0000;
        instr_next = 16'h0000; instr_valid = 1'b0;
        instr_fmt = oofd_pkg::OOFD_FMT_BYTE; mul_product = 16'h0000;
        mul_load = 1'b0; n_fail = 0; num_checks = 0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        t_regs;
        t_bank;
        t_fields;
        t_soft_mul;
        end_sim;
    end
endmodule

// ---- src/oofd_decoder.sv ----
// Operand field decoder with APB-visible core special registers
// Behaviour
// RL1: Access bit clear: access RAM, bank selector ignored.
// RL2: Access bit set: bank comes from the bank selector.
// RL3: Destination bit 0 to accumulator, 1 to file register.
// RL4: Bit field picks bit 0 to 7 of the file byte.
// RL5: File operand is an 8-bit address in one bank.
// RL6: Move source is a full 12-bit unbanked address.
// RL7: Move destination is a full 12-bit unbanked address.
// RL8: Literals are 8, 12 or 20 bits by format.
// RL9: Table mode: none, post-inc, post-dec, pre-inc.
// RL10: Branch field signed if relative, absolute for call/goto.
// RL11: Fast bit set uses shadow copies; clear leaves them.
// RL12: Don't-care bits never change the decode.
// RL13: Table pointer is 21 bits at its file address.
// RL14: Table latch holds the moved byte at its address.
// RL15: Product low and high bytes at their addresses.
// RL16: Accumulator reachable as a file register.
// RL17: Counter low, high and upper latches at consecutive addresses.
// RL18: Bank selector picks the active RAM bank.
// RL19: Selected_bank_symbol address is bank selector above the operand.
// RL20: Second word starts with four ones; alone a no-op.
//
// Added by the designer: the APB interface to the registers.
module oofd_decoder (
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [13:0]         paddr,
    input  wire logic [31:0]         pwdata,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    input  wire logic [15:0]         instr_word,
    input  wire logic [15:0]         instr_next,
    input  wire logic                instr_valid,
    input  wire oofd_pkg::oofd_fmt_t instr_fmt,
    input  wire logic [15:0]         mul_product,
    input  wire logic                mul_load,
    output oofd_pkg::oofd_dec_t      dec_out
);

    // --------------------------------
    // Functions
    // --------------------------------

    // Forms a full data address from access bit, bank and operand
    function automatic logic [11:0] file_address(
        input logic       acc_bit,
        input logic [3:0] bank,
        input logic [7:0] f
    );
        logic [11:0] a;
        a = 12'h000;
        if (acc_bit) begin
            a = {bank, f};                                    // RL2 RL19
        end else if (f < oofd_pkg::ACCESS_SPLIT) begin
            a = {4'h0, f};                                    // RL1
        end else begin
            // Upper half of access RAM sits in the top bank
            a = {4'hf, f};                                    // RL1
        end
        return a;
    endfunction

    // One-hot mask from a three-bit position
    function automatic logic [7:0] bit_select(input logic [2:0] b);
        logic [7:0] m;
        m = 8'h00;
        m[b] = 1'b1;                                          // RL4
        return m;
    endfunction

    // --------------------------------
    // Register state
    // --------------------------------
    logic [7:0]  working_accumulator;
    logic [7:0]  multiply_product_low;
    logic [7:0]  multiply_product_high;
    logic [7:0]  table_data_latch;
    logic [20:0] program_table_pointer;
    logic [7:0]  program_counter_low_byte;
    logic [7:0]  program_counter_high_latch;
    logic [7:0]  program_counter_upper_latch;
    logic [3:0]  bank_selector;
    logic [15:0] sw_word;
    logic [15:0] sw_next;
    logic [31:0] prdata_q;

    // Next-state copies of the register state
    logic [7:0]  next_working_accumulator;
    logic [7:0]  next_multiply_product_low;
    logic [7:0]  next_multiply_product_high;
    logic [7:0]  next_table_data_latch;
    logic [20:0] next_program_table_pointer;
    logic [7:0]  next_program_counter_low_byte;
    logic [7:0]  next_program_counter_high_latch;
    logic [7:0]  next_program_counter_upper_latch;
    logic [3:0]  next_bank_selector;
    logic [15:0] next_sw_word;
    logic [15:0] next_sw_next;
    logic [31:0] next_prdata;

    // Bus strobes, index and decode wires
    logic        wr_en;
    logic        rd_en;
    logic        hit;
    logic [11:0] reg_idx;
    logic [15:0] cur_word;
    logic [15:0] cur_next;
    oofd_pkg::oofd_dec_t dec_c;
    oofd_pkg::oofd_dec_t next_dec;

    // APB strobes: one-cycle access, no wait states
    assign wr_en   = psel & penable & pwrite;
    assign rd_en   = psel & ~penable & ~pwrite;
    assign reg_idx = paddr[13:2];
    assign pready  = 1'b1;

    // Address hit detection for slave error on unmapped indices
    always_comb begin
        case (reg_idx)
            oofd_pkg::ADDR_WORKING_ACCUMULATOR,
            oofd_pkg::ADDR_MULTIPLY_PRODUCT_LOW,
            oofd_pkg::ADDR_MULTIPLY_PRODUCT_HIGH,
            oofd_pkg::ADDR_TABLE_DATA_LATCH,
            oofd_pkg::ADDR_PROGRAM_TABLE_POINTER,
            oofd_pkg::ADDR_PROGRAM_COUNTER_LOW,
            oofd_pkg::ADDR_PROGRAM_COUNTER_HIGH,
            oofd_pkg::ADDR_PROGRAM_COUNTER_UPPER,
            oofd_pkg::ADDR_BANK_SELECTOR,
            oofd_pkg::ADDR_INSTR_WORD,
            oofd_pkg::ADDR_DECODE_A,
            oofd_pkg::ADDR_DECODE_B,
            oofd_pkg::ADDR_DECODE_C: hit = 1'b1;
            default:                 hit = 1'b0;
        endcase
    end
    assign pslverr = psel & penable & ~hit;
    // A refused write changes nothing; a refused read returns zero

    // --------------------------------
    // Instruction source: fetch port when valid, else software word
    // --------------------------------
    assign cur_word = instr_valid ? instr_word : sw_word;
    assign cur_next = instr_valid ? instr_next : sw_next;

    // --------------------------------
    // Operand decode
    // --------------------------------
    always_comb begin
        dec_c = '0;
        dec_c.tbl_mode = oofd_pkg::OOFD_TBL_NONE;
        // A lone second word decodes to nothing at all
        if (cur_word[15:12] == oofd_pkg::SECOND_WORD_TAG) begin
            dec_c.is_nop = 1'b1;                              // RL20
        end else begin
            case (instr_fmt)
                oofd_pkg::OOFD_FMT_BYTE: begin
                    dec_c.file_addr = file_address(cur_word[8],
                        bank_selector, cur_word[7:0]);        // RL5
                    dec_c.dest_file = cur_word[9];            // RL3
                end
                oofd_pkg::OOFD_FMT_BIT: begin
                    dec_c.file_addr = file_address(cur_word[8],
                        bank_selector, cur_word[7:0]);        // RL5
                    dec_c.bit_mask  = bit_select(cur_word[11:9]);
                end
                oofd_pkg::OOFD_FMT_LIT8: begin
                    dec_c.literal = {12'h000, cur_word[7:0]}; // RL8
                end
                oofd_pkg::OOFD_FMT_LIT12: begin
                    dec_c.literal = {8'h00, cur_word[3:0],
                                     cur_next[7:0]};          // RL8
                end
                oofd_pkg::OOFD_FMT_LIT20: begin
                    dec_c.literal     = {cur_next[11:0],
                                         cur_word[7:0]};      // RL8
                    dec_c.branch_abs  = 1'b1;                 // RL10
                    dec_c.fast_shadow = cur_word[8];          // RL11
                end
                oofd_pkg::OOFD_FMT_REL: begin
                    // Long form uses 11 bits, short form 8 bits
                    if (cur_word[15:12] == 4'hd) begin
                        dec_c.branch_offs = {{10{cur_word[10]}},
                                             cur_word[10:0]}; // RL10
                    end else begin
                        dec_c.branch_offs = {{13{cur_word[7]}},
                                             cur_word[7:0]};  // RL10
                    end
                end
                oofd_pkg::OOFD_FMT_TABLE: begin
                    dec_c.tbl_mode = oofd_pkg::oofd_tbl_t'(
                        cur_word[1:0]);                       // RL9 RL12
                    dec_c.fast_shadow = cur_word[0] &
                        (cur_word[15:4] == 12'h001);          // RL11
                end
                oofd_pkg::OOFD_FMT_MOVE: begin
                    dec_c.move_src = cur_word[11:0];          // RL6
                    dec_c.move_dst = cur_next[11:0];          // RL7
                end
                default: dec_c.is_nop = 1'b1;
            endcase
        end
    end
    assign next_dec = dec_c;

    // Decoded fields registered toward the datapath
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dec_out <= '0;
        end else begin
            dec_out <= next_dec;
        end
    end

    // --------------------------------
    // Register file next values
    // --------------------------------
    always_comb begin
        next_working_accumulator         = working_accumulator;
        next_multiply_product_low        = multiply_product_low;
        next_multiply_product_high       = multiply_product_high;
        next_table_data_latch            = table_data_latch;
        next_program_table_pointer       = program_table_pointer;
        next_program_counter_low_byte    = program_counter_low_byte;
        next_program_counter_high_latch  = program_counter_high_latch;
        next_program_counter_upper_latch = program_counter_upper_latch;
        next_bank_selector               = bank_selector;
        next_sw_word                     = sw_word;
        next_sw_next                     = sw_next;
        if (mul_load) begin
            next_multiply_product_low  = mul_product[7:0];    // RL15
            next_multiply_product_high = mul_product[15:8];   // RL15
        end
        // Bus write comes last so it beats a product load in one cycle
        if (wr_en) begin
            case (reg_idx)
                oofd_pkg::ADDR_WORKING_ACCUMULATOR:
                    next_working_accumulator = pwdata[7:0];   // RL16
                oofd_pkg::ADDR_MULTIPLY_PRODUCT_LOW:
                    next_multiply_product_low = pwdata[7:0];  // RL15
                oofd_pkg::ADDR_MULTIPLY_PRODUCT_HIGH:
                    next_multiply_product_high = pwdata[7:0]; // RL15
                oofd_pkg::ADDR_TABLE_DATA_LATCH:
                    next_table_data_latch = pwdata[7:0];      // RL14
                oofd_pkg::ADDR_PROGRAM_TABLE_POINTER:
                    next_program_table_pointer = pwdata[20:0]; // RL13
                oofd_pkg::ADDR_PROGRAM_COUNTER_LOW:
                    next_program_counter_low_byte = pwdata[7:0]; // RL17
                oofd_pkg::ADDR_PROGRAM_COUNTER_HIGH:
                    next_program_counter_high_latch = pwdata[7:0]; // RL17
                oofd_pkg::ADDR_PROGRAM_COUNTER_UPPER:
                    next_program_counter_upper_latch = pwdata[7:0]; // RL17
                oofd_pkg::ADDR_BANK_SELECTOR:
                    next_bank_selector = pwdata[3:0];         // RL18
                oofd_pkg::ADDR_INSTR_WORD: begin
                    next_sw_word = pwdata[15:0];
                    next_sw_next = pwdata[31:16];
                end
                default: begin
                end
            endcase
        end
    end

    // Read data mux, captured in the setup cycle
    always_comb begin
        next_prdata = prdata_q;
        if (rd_en) begin
            case (reg_idx)
                oofd_pkg::ADDR_WORKING_ACCUMULATOR:
                    next_prdata = {24'h000000, working_accumulator};
                oofd_pkg::ADDR_MULTIPLY_PRODUCT_LOW:
                    next_prdata = {24'h000000, multiply_product_low};
                oofd_pkg::ADDR_MULTIPLY_PRODUCT_HIGH:
                    next_prdata = {24'h000000, multiply_product_high};
                oofd_pkg::ADDR_TABLE_DATA_LATCH:
                    next_prdata = {24'h000000, table_data_latch};
                oofd_pkg::ADDR_PROGRAM_TABLE_POINTER:
                    next_prdata = {11'h000, program_table_pointer};
                oofd_pkg::ADDR_PROGRAM_COUNTER_LOW:
                    next_prdata = {24'h000000, program_counter_low_byte};
                oofd_pkg::ADDR_PROGRAM_COUNTER_HIGH:
                    next_prdata = {24'h000000, program_counter_high_latch};
                oofd_pkg::ADDR_PROGRAM_COUNTER_UPPER:
                    next_prdata = {24'h000000, program_counter_upper_latch};
                oofd_pkg::ADDR_BANK_SELECTOR:
                    next_prdata = {28'h0000000, bank_selector};
                oofd_pkg::ADDR_INSTR_WORD:
                    next_prdata = {sw_next, sw_word};
                oofd_pkg::ADDR_DECODE_A:
                    next_prdata = {dec_out.file_addr, dec_out.literal};
                oofd_pkg::ADDR_DECODE_B:
                    next_prdata = {dec_out.is_nop, dec_out.fast_shadow,
                                   dec_out.branch_abs, dec_out.dest_file,
                                   dec_out.tbl_mode, dec_out.bit_mask,
                                   dec_out.branch_offs[17:0]};
                oofd_pkg::ADDR_DECODE_C:
                    next_prdata = {8'h00, dec_out.move_dst,
                                   dec_out.move_src};
                default:
                    next_prdata = 32'h00000000;
            endcase
        end
    end

    // Read data stands until the next read setup cycle
    assign prdata = prdata_q;

    // Register file storage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            working_accumulator         <= oofd_pkg::RST_BYTE;
            multiply_product_low        <= oofd_pkg::RST_BYTE;
            multiply_product_high       <= oofd_pkg::RST_BYTE;
            table_data_latch            <= oofd_pkg::RST_BYTE;
            program_table_pointer       <= oofd_pkg::RST_TABLE_PTR;
            program_counter_low_byte    <= oofd_pkg::RST_BYTE;
            program_counter_high_latch  <= oofd_pkg::RST_BYTE;
            program_counter_upper_latch <= oofd_pkg::RST_BYTE;
            bank_selector               <= oofd_pkg::RST_BANK;
            sw_word                     <= oofd_pkg::RST_WORD;
            sw_next                     <= oofd_pkg::RST_WORD;
            prdata_q                    <= 32'h00000000;
        end else begin
            working_accumulator         <= next_working_accumulator;
            multiply_product_low        <= next_multiply_product_low;
            multiply_product_high       <= next_multiply_product_high;
            table_data_latch            <= next_table_data_latch;
            program_table_pointer       <= next_program_table_pointer;
            program_counter_low_byte    <= next_program_counter_low_byte;
            program_counter_high_latch  <= next_program_counter_high_latch;
            program_counter_upper_latch <= next_program_counter_upper_latch;
            bank_selector               <= next_bank_selector;
            sw_word                     <= next_sw_word;
            sw_next                     <= next_sw_next;
            prdata_q                    <= next_prdata;
        end
    end

endmodule

// ---- src/oofd_pkg.sv ----
// Package: register offsets, field layouts and types of the operand decoder
package oofd_pkg;

    // --------------------------------
    // Register indices; byte address is four times the index
    // --------------------------------
    localparam logic [11:0] ADDR_WORKING_ACCUMULATOR   = 12'hfe8;
    localparam logic [11:0] ADDR_MULTIPLY_PRODUCT_LOW  = 12'hff3;
    localparam logic [11:0] ADDR_MULTIPLY_PRODUCT_HIGH = 12'hff4;
    localparam logic [11:0] ADDR_TABLE_DATA_LATCH      = 12'hff5;
    localparam logic [11:0] ADDR_PROGRAM_TABLE_POINTER = 12'hff6;
    localparam logic [11:0] ADDR_PROGRAM_COUNTER_LOW   = 12'hff9;
    localparam logic [11:0] ADDR_PROGRAM_COUNTER_HIGH  = 12'hffa;
    localparam logic [11:0] ADDR_PROGRAM_COUNTER_UPPER = 12'hffb;
    // Indices of the bank, instruction and decode views
    localparam logic [11:0] ADDR_BANK_SELECTOR         = 12'h100;
    localparam logic [11:0] ADDR_INSTR_WORD            = 12'h101;
    localparam logic [11:0] ADDR_DECODE_A              = 12'h102;
    localparam logic [11:0] ADDR_DECODE_B              = 12'h103;
    localparam logic [11:0] ADDR_DECODE_C              = 12'h104;

    // --------------------------------
    // Reset values and widths
    // --------------------------------
    localparam logic [7:0]  RST_BYTE       = 8'h00;
    localparam logic [20:0] RST_TABLE_PTR  = 21'h000000;
    localparam logic [3:0]  RST_BANK       = 4'h0;
    localparam logic [15:0] RST_WORD       = 16'h0000;
    localparam logic [3:0]  SECOND_WORD_TAG = 4'hf;
    // Access RAM split: low half of bank 0, high half of bank 15
    localparam logic [7:0]  ACCESS_SPLIT   = 8'h80;

    // --------------------------------
    // Operand formats
    // --------------------------------
    typedef enum logic [2:0] {
        OOFD_FMT_BYTE,
        OOFD_FMT_BIT,
        OOFD_FMT_LIT8,
        OOFD_FMT_LIT12,
        OOFD_FMT_LIT20,
        OOFD_FMT_REL,
        OOFD_FMT_TABLE,
        OOFD_FMT_MOVE
    } oofd_fmt_t;

    typedef enum logic [1:0] {
        OOFD_TBL_NONE,
        OOFD_TBL_POST_INC,
        OOFD_TBL_POST_DEC,
        OOFD_TBL_PRE_INC
    } oofd_tbl_t;

    // Decoded operand fields handed to register file and datapath
    typedef struct packed {
        logic [11:0] file_addr;    // Full data address of file operand
        logic        dest_file;    // 1: result to file, 0: accumulator
        logic [7:0]  bit_mask;     // One-hot bit select
        logic [19:0] literal;      // Zero-extended literal
        logic [20:0] branch_offs;  // Sign-extended relative offset
        logic        branch_abs;   // Literal is absolute target
        logic        fast_shadow;  // Save/restore shadow copies
        oofd_tbl_t   tbl_mode;
        logic [11:0] move_src;
        logic [11:0] move_dst;
        logic        is_nop;       // Lone second word
    } oofd_dec_t;

endpackage
